//--- design/deser_ctrl_status_regs.sv
// control/status register bank of the serial-link video deserializer, 0x06..0x21
// What this block does
// - pattern-type bit picks standard (0) or legacy alternate (1) pattern checker.
// - with auto-clear set, decode counter clears 1us after error output asserts.
// - general input level forwarded to remote output unless forwarding is disabled.
// - data-enable glitch filter applied unless its disable bit is set.
// - vertical-sync glitch filter applied unless its disable bit is set.
// - horizontal-sync glitch filter applied unless its disable bit is set.
// - filter-disable bits power up 0 with strap low/high, 1 with strap open.
// - writable 8-bit decode error threshold at 0x0C, reset zero.
// - read-only 8-bit decode error counter at 0x0D, reset zero, writes ignored.
// - data-enable output inverted when the invert bit is set.
// - remote wake-up honoured unless the remote-wake disable bit is set.
// - high-immunity reverse bits at 500kbps, or 1Mbps when fast bit set.
// - audio clock from pixel clock or oscillator, 7-bit divider, zero disables.
// - auto-interrupt mode: info write drives pin high, info read drives low.
// - high-immunity bit selects reverse signalling; power-up value from strap.
//
// Design decision made here: the address-and-strobe port.
module deser_ctrl_status_regs #(
  parameter int FILT_LEN = 2
)(
  input wire logic clk,
  input wire logic rst,
  input wire deser_regs_pkg::reg_req_t req,
  output logic [7:0] rd_data,
  input wire logic bus_width_strap_open,
  input wire logic immunity_strap,
  input wire logic general_input_pin,
  output logic remote_general_output,
  input wire logic gp_pin0_in,
  output logic gp_pin0_out,
  output logic gp_pin0_oe,
  input wire logic gp_pin1_in,
  output logic gp_pin1_out,
  output logic gp_pin1_oe,
  input wire logic decode_error,
  input wire logic pattern_test_run,
  input wire logic pattern_error,
  output logic pattern_type_sel,
  output logic error_out,
  input wire deser_regs_pkg::video_sync_t video_in,
  output deser_regs_pkg::video_sync_t video_out,
  input wire logic remote_wake_req,
  output logic wake_out,
  output logic high_immunity_mode,
  output logic reverse_bit_tick,
  input wire logic pixel_output_clock,
  input wire logic osc_clock,
  output logic audio_mclk,
  input wire logic av_info_wr,
  input wire logic av_info_rd,
  output logic interrupt_output,
  output logic irq
);
  import deser_regs_pkg::*;

  localparam int FW = $clog2(FILT_LEN + 1);
  if (FILT_LEN < 2 || FILT_LEN > 15)
  begin : g_bad_filt_len
    $error("FILT_LEN must be 2..15");
  end
  logic [7:0] test_gpio_r, err_thr_r, dec_cnt_r, pat_cnt_r, audio_clk_r, rd_data_r, rd_mux;
  logic [2:0] filt_dis_r, out_wake_r, filt_q;
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_evt;
  logic [6:0] rev_cnt_r, mclk_cnt_r, rev_period;
  logic [5:0] clr_cnt_r;
  logic rev_fast_r, auto_int_r, high_imm_r, strap_done_r, err_r, rev_tick_r, mclk_r;
  logic src_prev_r, int_auto_r, int_pin_r, fwd_r, wake_r, wr_hit, auto_clear_fire;
  logic src_level, src_rise;
  video_sync_t vout_r;
  function automatic logic hit(input logic [7:0] off);
    hit = req.wr && (req.addr == off);
  endfunction
  // software-writable control bits; straps are caught on the first edge after release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      test_gpio_r <= {6'h00, RST_GP_DRIVE[1], 1'b0} | {4'h0, RST_GP_DRIVE[0], 3'h0};
      filt_dis_r <= 3'h0;
      high_imm_r <= 1'b0;
      strap_done_r <= 1'b0;
      err_thr_r <= RST_ZERO;
      out_wake_r <= 3'h0;
      rev_fast_r <= 1'b0;
      audio_clk_r <= RST_ZERO;
      auto_int_r <= RST_AUTO_INT;
      irq_mask_r <= '0;
    end
    else
    begin
      strap_done_r <= 1'b1;
      if (!strap_done_r)
      begin
        filt_dis_r <= {3{bus_width_strap_open}};
        high_imm_r <= immunity_strap;
      end
      if (hit(OFF_TEST_GPIO))
        test_gpio_r <= req.wdata;
      if (hit(OFF_SYNC_FILT))
        filt_dis_r <= req.wdata[2:0];
      if (hit(OFF_ERR_THR))
        err_thr_r <= req.wdata;
      if (hit(OFF_OUT_WAKE))
        out_wake_r <= req.wdata[2:0];
      if (hit(OFF_REV_RATE))
        rev_fast_r <= req.wdata[BIT_TOP];
      if (hit(OFF_AUDIO_CLK))
        audio_clk_r <= req.wdata;
      if (hit(OFF_AUTO_INT))
        auto_int_r <= req.wdata[BIT_TOP];
      if (hit(OFF_IMMUNITY))
        high_imm_r <= req.wdata[BIT_TOP];
      if (hit(OFF_IRQ_MASK))
        irq_mask_r <= req.wdata[IRQ_W-1:0];
    end
  end
  // decode errors: error output is judged against the threshold
  assign wr_hit = hit(OFF_DEC_ERR);
  assign auto_clear_fire = test_gpio_r[BIT_AUTO_CLR] && err_r &&
    (clr_cnt_r == 6'(AUTO_CLR_CYCLES - 1));
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dec_cnt_r <= RST_ZERO;
      err_r <= 1'b0;
      clr_cnt_r <= 6'h00;
    end
    else
    begin
      // counter saturates so a long burst never wraps back under the threshold
      if (auto_clear_fire)
        dec_cnt_r <= RST_ZERO;
      else if (decode_error && dec_cnt_r != 8'hff)
        dec_cnt_r <= dec_cnt_r + 8'h01;
      err_r <= !auto_clear_fire && (dec_cnt_r > err_thr_r);
      if (err_r && test_gpio_r[BIT_AUTO_CLR] && !auto_clear_fire)
        clr_cnt_r <= clr_cnt_r + 6'h01;
      else
        clr_cnt_r <= 6'h00;
    end
  end
  // pattern checker mismatches, only while the test runs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pat_cnt_r <= RST_ZERO;
    else if (pattern_test_run && pattern_error && pat_cnt_r != 8'hff)
      pat_cnt_r <= pat_cnt_r + 8'h01;
  end
  // glitch filters: a new level is taken only after FILT_LEN stable cycles
  for (genvar g = 0; g < 3; g++)
  begin : g_filt
    logic [FW-1:0] cnt_r;
    logic lvl_r;
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        cnt_r <= '0;
        lvl_r <= 1'b0;
      end
      else if (video_in[g] == lvl_r)
        cnt_r <= '0;
      else if (cnt_r == FW'(FILT_LEN - 1))
      begin
        lvl_r <= video_in[g];
        cnt_r <= '0;
      end
      else
        cnt_r <= cnt_r + FW'(1);
    end
    assign filt_q[g] = filt_dis_r[g] ? video_in[g] : lvl_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      vout_r <= '0;
    else
      vout_r <= {filt_q[2] ^ out_wake_r[BIT_DE_INV], filt_q[1], filt_q[0]};
  end
  // forwarding, wake-up and general pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fwd_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      if (!test_gpio_r[BIT_FWD_DIS])
        fwd_r <= general_input_pin;
      wake_r <= remote_wake_req && !out_wake_r[BIT_WAKE_DIS];
    end
  end
  // open-drain style: the pin is pulled low while its drive bit is 0
  assign gp_pin0_out = 1'b0;
  assign gp_pin1_out = 1'b0;
  assign gp_pin0_oe = !test_gpio_r[BIT_GP0_DRV];
  assign gp_pin1_oe = !test_gpio_r[BIT_GP1_DRV];
  // reverse channel bit clock, only in high-immunity signalling
  assign rev_period = rev_fast_r ? 7'(REV_FAST_CYCLES) : 7'(REV_SLOW_CYCLES);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rev_cnt_r <= 7'h00;
      rev_tick_r <= 1'b0;
    end
    else if (!high_imm_r)
    begin
      rev_cnt_r <= 7'h00;
      rev_tick_r <= 1'b0;
    end
    else
    begin
      rev_tick_r <= rev_cnt_r == rev_period - 7'h01;
      rev_cnt_r <= (rev_cnt_r >= rev_period - 7'h01) ? 7'h00 : rev_cnt_r + 7'h01;
    end
  end
  // audio master clock; divider 1 leaves the output high, a known limitation
  assign src_level = audio_clk_r[BIT_TOP] ? osc_clock : pixel_output_clock;
  assign src_rise = src_level && !src_prev_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      src_prev_r <= 1'b0;
      mclk_cnt_r <= 7'h00;
      mclk_r <= 1'b0;
    end
    else
    begin
      src_prev_r <= src_level;
      if (audio_clk_r[6:0] == 7'h00)
      begin
        mclk_cnt_r <= 7'h00;
        mclk_r <= 1'b0;
      end
      else if (src_rise)
      begin
        mclk_cnt_r <= (mclk_cnt_r >= audio_clk_r[6:0] - 7'h01) ? 7'h00 : mclk_cnt_r + 7'h01;
        mclk_r <= {1'b0, mclk_cnt_r} < (({1'b0, audio_clk_r[6:0]} + 8'h01) >> 1);
      end
    end
  end
  // interrupt pin: automatic from info-byte traffic, else from the register bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      int_auto_r <= 1'b0;
      int_pin_r <= 1'b0;
    end
    else
    begin
      // a write in the same cycle as a read wins, so the raise is not lost
      if (av_info_wr)
        int_auto_r <= 1'b1;
      else if (av_info_rd)
        int_auto_r <= 1'b0;
      int_pin_r <= auto_int_r ? (av_info_wr || (int_auto_r && !av_info_rd))
        : out_wake_r[BIT_INT_OUT];
    end
  end
  // sticky interrupt status, cleared by reading it; a new event beats the clear
  assign irq_evt[IRQ_DEC_ERR] = (dec_cnt_r > err_thr_r) && !err_r;
  assign irq_evt[IRQ_PAT_ERR] = pattern_test_run && pattern_error;
  assign irq_evt[IRQ_WAKE] = remote_wake_req && !out_wake_r[BIT_WAKE_DIS] && !wake_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_stat_r <= '0;
    else if (req.rd && req.addr == OFF_IRQ_STATUS)
      irq_stat_r <= irq_evt;
    else
      irq_stat_r <= irq_stat_r | irq_evt;
  end
  // read mux; reserved words read back their fixed values, unmapped read zero
  always_comb
  begin
    rd_mux = RST_ZERO;
    case (req.addr)
      OFF_TEST_GPIO: rd_mux = {test_gpio_r[7:5], general_input_pin, test_gpio_r[3],
        gp_pin1_in, test_gpio_r[1], gp_pin0_in};
      OFF_RSVD_A: rd_mux = RST_RSVD_A;
      OFF_SYNC_FILT: rd_mux = {RST_SYNC_FILT_HI, filt_dis_r};
      OFF_RSVD_B: rd_mux = RST_RSVD_B;
      OFF_RSVD_C: rd_mux = RST_RSVD_C;
      OFF_RSVD_D: rd_mux = RST_RSVD_D;
      OFF_ERR_THR: rd_mux = err_thr_r;
      OFF_DEC_ERR: rd_mux = dec_cnt_r;
      OFF_PAT_ERR: rd_mux = pat_cnt_r;
      OFF_OUT_WAKE: rd_mux = {5'h00, out_wake_r};
      OFF_RSVD_RO: rd_mux = RST_ZERO;
      OFF_REV_RATE: rd_mux = {rev_fast_r, RST_REV_RATE_LO};
      OFF_AUDIO_CLK: rd_mux = audio_clk_r;
      OFF_RSVD_E: rd_mux = RST_RSVD_E;
      OFF_AUTO_INT: rd_mux = {auto_int_r, 7'h00};
      OFF_IMMUNITY: rd_mux = {high_imm_r, RST_IMMUNITY_LO};
      OFF_IRQ_STATUS: rd_mux = {5'h00, irq_stat_r};
      OFF_IRQ_MASK: rd_mux = {5'h00, irq_mask_r};
      default: rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rd_data_r <= RST_ZERO;
    else if (req.rd)
      rd_data_r <= rd_mux;
    else
      rd_data_r <= RST_ZERO;
  end

  assign rd_data = rd_data_r;
  assign pattern_type_sel = test_gpio_r[BIT_PAT_TYPE];
  assign error_out = err_r;
  assign remote_general_output = fwd_r;
  assign wake_out = wake_r;
  assign video_out = vout_r;
  assign high_immunity_mode = high_imm_r;
  assign reverse_bit_tick = rev_tick_r;
  assign audio_mclk = mclk_r;
  assign interrupt_output = int_pin_r;
  assign irq = |(irq_stat_r & irq_mask_r);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_pattern_type_out: assert property (hit(OFF_TEST_GPIO)
    |=> pattern_type_sel == $past(req.wdata[BIT_PAT_TYPE]))
    else $error("pattern type select does not follow its bit");
  a_auto_clear_time: assert property ($rose(err_r) && test_gpio_r[BIT_AUTO_CLR]
    && !hit(OFF_TEST_GPIO) |-> ##[50:52] dec_cnt_r == 8'h00)
    else $error("decode counter not cleared about 1us after error");
  a_no_auto_clear: assert property (!test_gpio_r[BIT_AUTO_CLR] && dec_cnt_r != 8'h00
    |=> dec_cnt_r != 8'h00)
    else $error("decode counter cleared without auto-clear");
  a_forward_level: assert property (!$past(test_gpio_r[BIT_FWD_DIS])
    |-> remote_general_output == $past(general_input_pin))
    else $error("general input not forwarded");
  a_forward_hold: assert property ($past(test_gpio_r[BIT_FWD_DIS]) |-> $stable(fwd_r))
    else $error("forwarding continued while disabled");
  a_filter_bypass: assert property (filt_dis_r[1] && filt_dis_r[0]
    |=> video_out.vs == $past(video_in.vs) && video_out.hs == $past(video_in.hs))
    else $error("bypassed sync filter still filters");
  a_de_invert: assert property (filt_dis_r[2] |=> video_out.de ==
    ($past(video_in.de) ^ $past(out_wake_r[BIT_DE_INV])))
    else $error("data enable bypass or inversion wrong");
  a_filter_reject: assert property (!filt_dis_r[0] && $changed(video_in.hs)
    ##1 $changed(video_in.hs) && !filt_dis_r[0] |=> ##1 $stable(video_out.hs))
    else $error("one-cycle glitch passed the filter");
  a_strap_load: assert property ($fell(strap_done_r) or (!$past(strap_done_r)
    && strap_done_r) |-> filt_dis_r == {3{$past(bus_width_strap_open)}})
    else $error("filter-disable bits not loaded from strap");
  a_error_judge: assert property (!auto_clear_fire |=> error_out ==
    ($past(dec_cnt_r) > $past(err_thr_r)))
    else $error("error output disagrees with threshold");
  a_count_readonly: assert property (wr_hit && !decode_error && !auto_clear_fire
    |=> $stable(dec_cnt_r))
    else $error("write changed the decode counter");
  a_wake_gate: assert property (out_wake_r[BIT_WAKE_DIS] |=> !wake_out)
    else $error("remote wake honoured while disabled");
  a_rev_spacing: assert property ($rose(reverse_bit_tick) && high_imm_r && !rev_fast_r
    ##1 (high_imm_r && !rev_fast_r)[*8] |-> !reverse_bit_tick)
    else $error("reverse bit tick too close");
  a_mclk_off: assert property (audio_clk_r[6:0] == 7'h00 |=> !audio_mclk)
    else $error("audio clock runs with divider zero");
  a_auto_int: assert property (auto_int_r && av_info_wr |=> interrupt_output)
    else $error("info write did not raise interrupt pin");
  a_auto_int_low: assert property (auto_int_r && av_info_rd && !av_info_wr
    |=> !interrupt_output)
    else $error("info read did not lower interrupt pin");
  a_int_bit: assert property (!auto_int_r |=> interrupt_output ==
    $past(out_wake_r[BIT_INT_OUT]))
    else $error("interrupt pin does not follow its bit");
  a_pin_drive: assert property (hit(OFF_TEST_GPIO) |=> gp_pin0_oe ==
    !$past(req.wdata[BIT_GP0_DRV]) && gp_pin1_oe == !$past(req.wdata[BIT_GP1_DRV]))
    else $error("general pin drive mismatch");
  a_pattern_count: assert property (!pattern_test_run |=> $stable(pat_cnt_r))
    else $error("pattern counter moved while test idle");

  c_auto_clear: cover property (auto_clear_fire);
  c_error_raise: cover property ($rose(error_out));
  c_irq_fire: cover property ($rose(irq));
  c_mclk_toggle: cover property ($rose(audio_mclk));
endmodule

//--- design/deser_regs_pkg.sv
// constants, register map and carrier types of the deserializer control/status bank
package deser_regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [7:0] OFF_TEST_GPIO = 8'h06;
  localparam logic [7:0] OFF_RSVD_A = 8'h07;
  localparam logic [7:0] OFF_SYNC_FILT = 8'h08;
  localparam logic [7:0] OFF_RSVD_B = 8'h09;
  localparam logic [7:0] OFF_RSVD_C = 8'h0a;
  localparam logic [7:0] OFF_RSVD_D = 8'h0b;
  localparam logic [7:0] OFF_ERR_THR = 8'h0c;
  localparam logic [7:0] OFF_DEC_ERR = 8'h0d;
  localparam logic [7:0] OFF_PAT_ERR = 8'h0e;
  localparam logic [7:0] OFF_OUT_WAKE = 8'h0f;
  localparam logic [7:0] OFF_RSVD_RO = 8'h10;
  localparam logic [7:0] OFF_REV_RATE = 8'h11;
  localparam logic [7:0] OFF_AUDIO_CLK = 8'h12;
  localparam logic [7:0] OFF_RSVD_E = 8'h13;
  localparam logic [7:0] OFF_AUTO_INT = 8'h15;
  localparam logic [7:0] OFF_IMMUNITY = 8'h16;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h21;
  // reset values
  localparam logic [7:0] RST_RSVD_A = 8'h54;
  localparam logic [7:0] RST_RSVD_B = 8'hc8;
  localparam logic [7:0] RST_RSVD_C = 8'h10;
  localparam logic [7:0] RST_RSVD_D = 8'h20;
  localparam logic [7:0] RST_RSVD_E = 8'h10;
  localparam logic [4:0] RST_SYNC_FILT_HI = 5'h06;
  localparam logic [6:0] RST_REV_RATE_LO = 7'h22;
  localparam logic [6:0] RST_IMMUNITY_LO = 7'h5a;
  localparam logic [1:0] RST_GP_DRIVE = 2'h3;
  localparam logic RST_AUTO_INT = 1'b1;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // field positions
  localparam int BIT_PAT_TYPE = 7;
  localparam int BIT_AUTO_CLR = 6;
  localparam int BIT_FWD_DIS = 5;
  localparam int BIT_GPI_LVL = 4;
  localparam int BIT_GP1_DRV = 3;
  localparam int BIT_GP1_LVL = 2;
  localparam int BIT_GP0_DRV = 1;
  localparam int BIT_GP0_LVL = 0;
  localparam int BIT_DE_INV = 2;
  localparam int BIT_WAKE_DIS = 1;
  localparam int BIT_INT_OUT = 0;
  localparam int BIT_TOP = 7;
  // interrupt status bits
  localparam int IRQ_DEC_ERR = 0;
  localparam int IRQ_PAT_ERR = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_W = 3;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int AUTO_CLR_NS = 1000;
  localparam int AUTO_CLR_CYCLES = AUTO_CLR_NS / CLK_PERIOD_NS;
  localparam int REV_SLOW_BIT_NS = 2000;
  localparam int REV_FAST_BIT_NS = 1000;
  localparam int REV_SLOW_CYCLES = REV_SLOW_BIT_NS / CLK_PERIOD_NS;
  localparam int REV_FAST_CYCLES = REV_FAST_BIT_NS / CLK_PERIOD_NS;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic de;
    logic vs;
    logic hs;
  } video_sync_t;
endpackage

//--- tb/remote_partner.sv
// far-end model: serializer error, wake and remote output sources
module remote_partner (
  input wire logic clk,
  input wire logic fwd_level,
  output logic decode_error,
  output logic pattern_error,
  output logic remote_wake_req,
  output logic remote_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    decode_error = 1'b0;
    pattern_error = 1'b0;
    remote_wake_req = 1'b0;
  end
  // remote pin lags the forwarded level by a cycle, as across the link
  always @(posedge clk)
  begin
    remote_pin <= fwd_level;
  end
  // pulses spaced by an idle cycle so every one is a separate event
  task automatic pulse(input bit pat, input int n);
    repeat (n)
    begin
      @(posedge clk);
      if (pat)
        pattern_error <= 1'b1;
      else
        decode_error <= 1'b1;
      @(posedge clk);
      pattern_error <= 1'b0;
      decode_error <= 1'b0;
    end
  endtask
  task automatic wake(input bit v);
    @(posedge clk);
    remote_wake_req <= v;
  endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the deserializer control/status register bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import deser_regs_pkg::*;
  logic clk, rst, strap_open, imm_strap, gin, gp0_ext, gp1_ext, pat_run, osc_clk, av_wr, av_rd;
  logic rgo, gp0_out, gp0_oe, gp1_out, gp1_oe, dec_err, pat_err, pat_sel, err_out, wake_req;
  logic wake_out, hi_mode, rtick, mclk, intpin, irq, rpin, gp0_in, gp1_in, pix_clk;
  logic [1:0] pdiv;
  logic [7:0] a, d, rd_data;
  logic [7:0] sh [0:255];
  logic [7:0] alist [16] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
    8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h21, 8'h30};
  reg_req_t req;
  video_sync_t vin, vout;
  int fail_count, n_tests, n;
  // open-drain pins: pulled low while enabled, otherwise the outside level
  assign gp0_in = gp0_oe ? 1'b0 : gp0_ext;
  assign gp1_in = gp1_oe ? 1'b0 : gp1_ext;
  assign pix_clk = pdiv[1];
  deser_ctrl_status_regs #(.FILT_LEN(2)) dut (.clk(clk), .rst(rst), .req(req),
    .rd_data(rd_data), .bus_width_strap_open(strap_open), .immunity_strap(imm_strap),
    .general_input_pin(gin), .remote_general_output(rgo), .gp_pin0_in(gp0_in),
    .gp_pin0_out(gp0_out), .gp_pin0_oe(gp0_oe), .gp_pin1_in(gp1_in), .gp_pin1_out(gp1_out),
    .gp_pin1_oe(gp1_oe), .decode_error(dec_err), .pattern_test_run(pat_run),
    .pattern_error(pat_err), .pattern_type_sel(pat_sel), .error_out(err_out),
    .video_in(vin), .video_out(vout), .remote_wake_req(wake_req), .wake_out(wake_out),
    .high_immunity_mode(hi_mode), .reverse_bit_tick(rtick), .pixel_output_clock(pix_clk),
    .osc_clock(osc_clk), .audio_mclk(mclk), .av_info_wr(av_wr), .av_info_rd(av_rd),
    .interrupt_output(intpin), .irq(irq));
  remote_partner partner (.clk(clk), .fwd_level(rgo), .decode_error(dec_err),
    .pattern_error(pat_err), .remote_wake_req(wake_req), .remote_pin(rpin));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    osc_clk <= ~osc_clk;
    pdiv <= pdiv + 2'd1;
  end
  function automatic logic [7:0] fixed_val(input logic [7:0] x, input logic open);
    case (x)
      8'h06: return 8'h0a;
      8'h07: return 8'h54;
      8'h08: return open ? 8'h37 : 8'h30;
      8'h09: return 8'hc8;
      8'h0a, 8'h13: return 8'h10;
      8'h0b: return 8'h20;
      8'h11: return 8'h22;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] wmask(input logic [7:0] x);
    case (x)
      8'h06: return 8'hea;
      8'h08, 8'h0f, 8'h21: return 8'h07;
      8'h0c, 8'h12: return 8'hff;
      8'h11: return 8'h80;
      default: return 8'h00;
    endcase
  endfunction
  // live pin levels show through the read-only bits of 0x06
  function automatic logic [7:0] expv(input logic [7:0] x);
    logic [7:0] live;
    live = (x == 8'h06) ? {3'b000, gin, 1'b0, gp1_in, 1'b0, gp0_in} : 8'h00;
    return (sh[x] & wmask(x)) | (fixed_val(x, 1'b1) & ~wmask(x)) | live;
  endfunction
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] x, input logic [7:0] v);
    @(posedge clk);
    req <= '{addr: x, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // data stand one cycle only, so the idle cycle after must read zero
  task automatic rchk(input logic [7:0] x, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: x, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rd_data, exp);
    tick_n(1);
    chk(rd_data, 8'h00);
  endtask
  task automatic pulse_av(input logic w, input logic r);
    @(posedge clk);
    av_wr <= w;
    av_rd <= r;
    @(posedge clk);
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    #1;
  endtask
  task automatic wait_err(input logic v, input int lim);
    n = 0;
    while (err_out !== v && n < lim)
    begin
      tick_n(1);
      n++;
    end
    if (n >= lim)
    begin
      fail_count++;
      finish_test();
    end
  endtask
  // rising edges in a fixed 300-cycle window
  task automatic cnt(input bit sel, output int k);
    logic p, s;
    p = 1'b0;
    k = 0;
    repeat (300)
    begin
      @(posedge clk);
      #1 s = sel ? rtick : mclk;
      if (s && !p)
        k++;
      p = s;
    end
  endtask
  initial
  begin
    rst = 1'b1;
    req = '0;
    {strap_open, imm_strap} = 2'b11;
    {gin, gp0_ext, gp1_ext, pat_run, osc_clk, av_wr, av_rd} = '0;
    pdiv = 2'd0;
    vin = '0;
    fail_count = 0;
    n_tests = 0;
    for (int i = 0; i < 256; i++)
      sh[i] = fixed_val(8'(i), 1'b1);
    void'($urandom(99));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    tick_n(3);
    foreach (alist[i])
      rchk(alist[i], expv(alist[i]));
    rchk(8'h16, 8'hda);
    repeat (40)
    begin
      a = alist[$urandom % 16];
      d = 8'($urandom);
      wr(a, d);
      sh[a] = d;
      {gin, gp0_ext, gp1_ext} <= 3'($urandom);
      tick_n(3);
      rchk(a, expv(a));
    end
    wr(8'h06, 8'h4a);
    wr(8'h0c, 8'h00);
    rchk(8'h20, 8'h00);
    partner.pulse(1'b0, 1);
    wait_err(1'b1, 10);
    wait_err(1'b0, 200);
    chk(8'(n), 8'(AUTO_CLR_CYCLES));
    rchk(8'h0d, 8'h00);
    wr(8'h06, 8'h0a);
    wr(8'h0c, 8'h03);
    partner.pulse(1'b0, 3);
    tick_n(3);
    chk(err_out, 1'b0);
    rchk(8'h0d, 8'h03);
    partner.pulse(1'b0, 1);
    tick_n(60);
    chk(err_out, 1'b1);
    wr(8'h0d, 8'h00);
    rchk(8'h0d, 8'h04);
    wr(8'h21, 8'h00);
    tick_n(1);
    chk(irq, 1'b0);
    wr(8'h21, 8'h01);
    tick_n(1);
    chk(irq, 1'b1);
    rchk(8'h20, 8'h01);
    chk(irq, 1'b0);
    wr(8'h0f, 8'h00);
    partner.wake(1'b1);
    tick_n(2);
    chk(wake_out, 1'b1);
    partner.wake(1'b0);
    wr(8'h0f, 8'h02);
    partner.wake(1'b1);
    tick_n(2);
    chk(wake_out, 1'b0);
    partner.wake(1'b0);
    chk(irq, 1'b0);
    wr(8'h21, 8'h04);
    tick_n(1);
    chk(irq, 1'b1);
    rchk(8'h20, 8'h04);
    partner.pulse(1'b1, 2);
    pat_run <= 1'b1;
    partner.pulse(1'b1, 5);
    tick_n(2);
    rchk(8'h0e, 8'h05);
    wr(8'h06, 8'h8a);
    tick_n(1);
    chk(pat_sel, 1'b1);
    wr(8'h06, 8'h08);
    tick_n(1);
    chk({gp1_oe, gp0_oe, gp1_out, gp0_out}, 8'h04);
    gin <= 1'b0;
    tick_n(4);
    gin <= 1'b1;
    tick_n(4);
    chk(rpin, 1'b1);
    wr(8'h06, 8'h28);
    gin <= 1'b0;
    tick_n(4);
    chk(rpin, 1'b1);
    wr(8'h0f, 8'h00);
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h08, 8'(m));
      tick_n(3);
      vin <= 3'b111;
      tick_n(1);
      vin <= 3'b000;
      chk(vout, 8'(m));
      tick_n(3);
    end
    wr(8'h0f, 8'h04);
    tick_n(4);
    chk(vout, 8'h04);
    vin <= 3'b111;
    tick_n(5);
    chk(vout, 8'h03);
    pulse_av(1'b1, 1'b0);
    chk(intpin, 1'b1);
    pulse_av(1'b0, 1'b1);
    chk(intpin, 1'b0);
    pulse_av(1'b1, 1'b1);
    chk(intpin, 1'b1);
    wr(8'h15, 8'h00);
    wr(8'h0f, 8'h00);
    tick_n(1);
    pulse_av(1'b1, 1'b0);
    chk(intpin, 1'b0);
    wr(8'h0f, 8'h01);
    tick_n(1);
    chk(intpin, 1'b1);
    wr(8'h11, 8'h00);
    tick_n(120);
    cnt(1'b1, n);
    chk(8'(n), 8'd3);
    wr(8'h11, 8'h80);
    tick_n(120);
    cnt(1'b1, n);
    chk(8'(n), 8'd6);
    wr(8'h16, 8'h00);
    tick_n(120);
    cnt(1'b1, n);
    chk({hi_mode, 7'(n)}, 8'h00);
    wr(8'h12, 8'h00);
    cnt(1'b0, n);
    chk(8'(n), 8'd0);
    wr(8'h12, 8'h82);
    tick_n(20);
    cnt(1'b0, n);
    chk(8'(n >= 74 && n <= 76), 8'd1);
    wr(8'h12, 8'h02);
    tick_n(20);
    cnt(1'b0, n);
    chk(8'(n >= 36 && n <= 39), 8'd1);
    strap_open <= 1'b0;
    rst <= 1'b1;
    tick_n(2);
    rst <= 1'b0;
    tick_n(3);
    rchk(8'h08, 8'h30);
    finish_test();
  end
endmodule
